/* core/pac_pkg.sv */
package pac_pkg;
   // Address split: menu number in the upper field, parameter in the lower
   localparam int PAC_MENU_W = 5;
   localparam int PAC_PARAM_W = 5;
   localparam int PAC_ADDR_W = PAC_MENU_W + PAC_PARAM_W;
   localparam int PAC_DATA_W = 12;
   localparam int PAC_DEPTH = 1 << PAC_ADDR_W;
   localparam int PAC_NUM_MENU = 16;
   // Value limits for real-valued parameters
   localparam logic signed [11:0] PAC_VAL_MIN = -12'sd1999;
   localparam logic signed [11:0] PAC_VAL_MAX = 12'sd1999;
   // Command slot codes
   localparam logic [11:0] PAC_CODE_SAVE = 12'h001;
   localparam logic [11:0] PAC_CODE_LVL1 = 12'h095;
   localparam logic [11:0] PAC_CODE_LVL2 = 12'h0C8;
   localparam logic [11:0] PAC_CODE_FACT_NREG = 12'h0FF;
   localparam logic [11:0] PAC_CODE_FACT_REG = 12'h0E9;
   localparam logic [11:0] PAC_CODE_NONE = 12'h000;
   // Security code parameter lives at menu 11, parameter 17
   localparam logic [9:0] PAC_SEC_ADDR = 10'h171;
   localparam logic [11:0] PAC_SEC_RESET = 12'h095;
   localparam logic [11:0] PAC_VAL_RESET = 12'h000;
   // Write sources
   localparam logic [1:0] PAC_SRC_KEYPAD = 2'h0;
   localparam logic [1:0] PAC_SRC_SERIAL = 2'h1;
   localparam logic [1:0] PAC_SRC_PROG = 2'h2;
   // Pending reset-time commands
   typedef enum logic [1:0] {PAC_CMD_NONE, PAC_CMD_SAVE, PAC_CMD_FNREG, PAC_CMD_FREG} pac_cmd_t;
   typedef enum logic [1:0] {PAC_ST_LOAD, PAC_ST_IDLE, PAC_ST_APPLY} pac_state_t;
endpackage : pac_pkg

/* core/pac_store.sv */
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
module pac_store
   import pac_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_n_in,
   // Register port
   input wire logic [PAC_ADDR_W-1:0] addr_in,
   input wire logic [PAC_DATA_W-1:0] wdata_in,
   input wire logic [1:0] wsrc_in,
   input wire logic wr_stb_in,
   input wire logic rd_stb_in,
   output logic [PAC_DATA_W-1:0] rdata_out,
   output logic rd_err_out,
   output logic wr_err_out,
   // Attributes of the addressed or selected parameter
   input wire logic attr_read_only_class_in,
   input wire logic attr_invisible_in,
   input wire logic attr_bit_in,
   input wire logic attr_free_in,
   input wire logic attr_deferred_in,
   input wire logic attr_input_driven_in,
   // Drive side
   input wire logic meas_we_in,
   input wire logic drv_reset_in,
   input wire logic drv_stopped_in,
   input wire logic [PAC_ADDR_W-1:0] ctl_addr_in,
   output logic [PAC_DATA_W-1:0] ctl_data_out,
   // Keypad selection and display
   input wire logic sel_menu_stb_in,
   input wire logic sel_param_stb_in,
   input wire logic [PAC_MENU_W-1:0] sel_menu_in,
   input wire logic [PAC_PARAM_W-1:0] sel_param_in,
   input wire logic mode_key_in,
   output logic [PAC_MENU_W-1:0] index_menu_out,
   output logic [PAC_PARAM_W-1:0] index_param_out,
   output logic index_blank_out,
   output logic flash_out,
   output logic busy_out
);

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      pac_state_t state;
      logic [PAC_ADDR_W-1:0] walk;
      pac_cmd_t cmd;
      logic [PAC_DATA_W-1:0] rdata;
      logic rd_err;
      logic wr_err;
      logic lvl1;
      logic lvl2;
      logic l3ok;
      logic [PAC_DATA_W-1:0] sec_code;
      logic adjust;
      logic flash;
      logic [PAC_MENU_W-1:0] sel_menu;
      logic [PAC_PARAM_W-1:0] sel_param;
      logic blank;
      logic [PAC_DATA_W-1:0] ctl_data;
      logic busy;
   } pac_state_reg_t;

   pac_state_reg_t st_reg;
   pac_state_reg_t st_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;

   // Volatile store, applied copy, saved copy and bookkeeping
   logic [PAC_DATA_W-1:0] val_mem [PAC_DEPTH];
   logic [PAC_DATA_W-1:0] act_mem [PAC_DEPTH];
   logic [PAC_DATA_W-1:0] nv_mem [PAC_DEPTH];
   logic nv_ok_mem [PAC_DEPTH];
   logic dirty_mem [PAC_DEPTH];
   logic [PAC_PARAM_W-1:0] last_mem [1 << PAC_MENU_W];

   logic val_we;
   logic act_we;
   logic nv_we;
   logic dirty_we;
   logic dirty_val;
   logic [PAC_ADDR_W-1:0] mem_addr;
   logic [PAC_DATA_W-1:0] mem_data;
   logic l3cfg;
   logic wr_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // Default table; only the security code differs from zero
   function automatic logic [PAC_DATA_W-1:0] pac_dflt(input logic [PAC_ADDR_W-1:0] a);
      pac_dflt = (a == PAC_SEC_ADDR) ? PAC_SEC_RESET : PAC_VAL_RESET;
   endfunction : pac_dflt

   // Read permission for the current security state
   function automatic logic pac_can_read(input pac_state_reg_t s, input logic l3c,
                                          input logic inv);
      pac_can_read = !(l3c && !s.l3ok) && (!inv || s.lvl2);
   endfunction : pac_can_read

   // Write permission, ignoring value range and the command slot
   function automatic logic pac_can_write(input pac_state_reg_t s, input logic l3c,
                                           input logic [PAC_DATA_W-1:0] code,
                                           input logic [1:0] src);
      logic unlocked;
      unlocked = (code == PAC_CODE_NONE) || s.lvl2 ||
                 (!attr_invisible_in && (s.lvl1 || (attr_free_in && !l3c)));
      pac_can_write = !attr_read_only_class_in && unlocked && !(l3c && !s.l3ok) &&
                      !(src == PAC_SRC_KEYPAD && attr_input_driven_in);
   endfunction : pac_can_write

   // Level three counts only when set to something other than none or level one
   assign l3cfg = (st_reg.sec_code != PAC_CODE_NONE) && (st_reg.sec_code != PAC_CODE_LVL1);
   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic in_range;
      logic param_zero;
      in_range = ($signed(wdata_in) >= PAC_VAL_MIN) && ($signed(wdata_in) <= PAC_VAL_MAX);
      param_zero = (addr_in[PAC_PARAM_W-1:0] == '0);
      st_next = st_reg;
      st_next.rd_err = 1'b0;
      st_next.wr_err = 1'b0;
      val_we = 1'b0;
      act_we = 1'b0;
      nv_we = 1'b0;
      dirty_we = 1'b0;
      dirty_val = 1'b0;
      mem_addr = addr_in;
      mem_data = wdata_in;
      wr_ok = 1'b0;
      st_next.ctl_data = act_mem[ctl_addr_in];
      unique case (st_reg.state)
         PAC_ST_LOAD: begin
            // Saved value wins over the power-on default
            // A blank saved flag counts as unset, so an erased store gives defaults
            mem_addr = st_reg.walk;
            if (nv_ok_mem[st_reg.walk]) begin
               mem_data = nv_mem[st_reg.walk];
            end else begin
               mem_data = pac_dflt(st_reg.walk);
            end
            val_we = 1'b1;
            act_we = 1'b1;
            dirty_we = 1'b1;
         end
         PAC_ST_APPLY: begin
            mem_addr = st_reg.walk;
            mem_data = val_mem[st_reg.walk];
            act_we = 1'b1; // Deferred values take effect here
            if (st_reg.cmd == PAC_CMD_SAVE && dirty_mem[st_reg.walk]) begin
               nv_we = 1'b1;
               dirty_we = 1'b1;
            end else if (st_reg.cmd == PAC_CMD_FNREG || st_reg.cmd == PAC_CMD_FREG) begin
               // Both flavours share one table here
               mem_data = pac_dflt(st_reg.walk);
               val_we = 1'b1;
               dirty_we = 1'b1;
               dirty_val = 1'b1;
            end
         end
         PAC_ST_IDLE: begin
            if (wr_stb_in && param_zero) begin
               // Command slot: codes and reset-time commands
               if (!(l3cfg && !st_reg.l3ok)) begin
                  st_next.lvl1 = st_reg.lvl1 || (wdata_in == PAC_CODE_LVL1);
                  st_next.lvl2 = st_reg.lvl2 || (wdata_in == PAC_CODE_LVL2);
               end
               if (l3cfg && wdata_in == st_reg.sec_code) begin
                  st_next.l3ok = 1'b1;
               end
               unique case (wdata_in)
                  PAC_CODE_SAVE: st_next.cmd = PAC_CMD_SAVE;
                  PAC_CODE_FACT_NREG: st_next.cmd = PAC_CMD_FNREG;
                  PAC_CODE_FACT_REG: st_next.cmd = PAC_CMD_FREG;
                  default: st_next.cmd = PAC_CMD_NONE;
               endcase
            end else if (wr_stb_in) begin
               wr_ok = pac_can_write(st_reg, l3cfg, st_reg.sec_code, wsrc_in) && in_range &&
                       (!attr_bit_in || wdata_in <= 12'h001);
               st_next.wr_err = !wr_ok; // Nothing stored on refusal
               val_we = wr_ok; // Volatile until saved
               act_we = wr_ok && !attr_deferred_in;
               dirty_we = wr_ok;
               dirty_val = 1'b1;
               if (wr_ok && addr_in == PAC_SEC_ADDR) begin
                  st_next.sec_code = wdata_in;
               end
            end else if (meas_we_in) begin
               // Drive-owned update, ignores security
               val_we = 1'b1;
               act_we = 1'b1;
            end
            if (drv_reset_in && !wr_stb_in) begin
               // Factory reload relies on the drive being stopped
               if (!(st_reg.cmd inside {PAC_CMD_FNREG, PAC_CMD_FREG}) || drv_stopped_in) begin
                  st_next.state = PAC_ST_APPLY;
               end
               st_next.walk = '0;
            end
         end
      endcase
      if (st_reg.state != PAC_ST_IDLE) begin
         st_next.walk = st_reg.walk + 1'b1;
         st_next.wr_err = wr_stb_in; // Refused while walking
         if (st_reg.walk == PAC_SEC_ADDR) begin
            st_next.sec_code = mem_data;
         end
         if (st_reg.walk == PAC_ADDR_W'(PAC_DEPTH - 1)) begin
            st_next.state = PAC_ST_IDLE;
            st_next.cmd = PAC_CMD_NONE;
         end
      end
      // Read answers one cycle later
      if (rd_stb_in) begin
         st_next.rd_err = !pac_can_read(st_reg, l3cfg, attr_invisible_in);
         st_next.rdata = st_next.rd_err ? '0 : val_mem[addr_in];
      end
      // Keypad selection recalls the menu's last parameter
      if (sel_menu_stb_in) begin
         st_next.sel_menu = sel_menu_in;
         st_next.sel_param = last_mem[sel_menu_in];
         st_next.adjust = 1'b0;
      end else if (sel_param_stb_in) begin
         st_next.sel_param = sel_param_in;
         st_next.adjust = 1'b0;
      end
      if (sel_menu_stb_in || sel_param_stb_in) begin
         st_next.blank = attr_invisible_in && !st_reg.lvl2;
      end
      // Mode key toggles adjustment; flash only when writable
      if (mode_key_in && !sel_menu_stb_in && !sel_param_stb_in) begin
         st_next.adjust = !st_reg.adjust;
      end
      st_next.flash = st_next.adjust && ((st_reg.sel_param == '0) ||
                      pac_can_write(st_reg, l3cfg, st_reg.sec_code, PAC_SRC_KEYPAD));
      // Busy kept as its own flop so the output needs no decode
      st_next.busy = (st_next.state != PAC_ST_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // State register; levels cleared at power-up
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '{state: PAC_ST_LOAD, cmd: PAC_CMD_NONE, sec_code: PAC_SEC_RESET,
                     busy: 1'b1, default: '0};
      end else begin
         st_reg <= st_next;
      end
   end

   // Arrays carry no reset; the saved copy outlives a reset
   always_ff @(posedge mclk_in) begin
      if (val_we) begin
         val_mem[mem_addr] <= mem_data;
      end
      if (act_we) begin
         act_mem[mem_addr] <= mem_data;
      end
      if (nv_we) begin
         nv_mem[mem_addr] <= mem_data;
         nv_ok_mem[mem_addr] <= 1'b1;
      end
      if (dirty_we) begin
         dirty_mem[mem_addr] <= dirty_val;
      end
      if (sel_param_stb_in && !sel_menu_stb_in) begin
         last_mem[st_reg.sel_menu] <= sel_param_in;
      end else if (st_reg.state == PAC_ST_LOAD) begin
         // Power-up forgets every menu's recall
         last_mem[st_reg.walk[PAC_MENU_W-1:0]] <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops
   assign rdata_out = st_reg.rdata;
   assign rd_err_out = st_reg.rd_err;
   assign wr_err_out = st_reg.wr_err;
   assign ctl_data_out = st_reg.ctl_data;
   assign index_menu_out = st_reg.sel_menu;
   assign index_param_out = st_reg.sel_param;
   assign index_blank_out = st_reg.blank;
   assign flash_out = st_reg.flash;
   assign busy_out = st_reg.busy;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_bad_write;
      wr_stb_in && !busy_out && addr_in[PAC_PARAM_W-1:0] != '0;
   endsequence

   chk_range_guard: assert property (@(posedge mclk_in) disable iff (!rst_n)
      s_bad_write and ($signed(wdata_in) > PAC_VAL_MAX) |=> wr_err_out)
      else $error("out of range write accepted");
   chk_bit_guard: assert property (@(posedge mclk_in) disable iff (!rst_n)
      s_bad_write and (attr_bit_in && wdata_in > 12'h001) |=> wr_err_out)
      else $error("bit parameter took non-binary value");
   chk_ro_reject: assert property (@(posedge mclk_in) disable iff (!rst_n)
      s_bad_write and attr_read_only_class_in |-> !wr_ok ##1 wr_err_out)
      else $error("read-only parameter written");
   chk_keypad_block: assert property (@(posedge mclk_in) disable iff (!rst_n)
      s_bad_write and (wsrc_in == PAC_SRC_KEYPAD && attr_input_driven_in) |-> !val_we)
      else $error("input-driven parameter written from keypad");
   chk_l3_lock: assert property (@(posedge mclk_in) disable iff (!rst_n)
      rd_stb_in && l3cfg && !st_reg.l3ok |=> rd_err_out && rdata_out == '0)
      else $error("read allowed before level three code");
   chk_vis_read: assert property (@(posedge mclk_in) disable iff (!rst_n)
      rd_stb_in && !attr_invisible_in && !l3cfg |=> !rd_err_out)
      else $error("visible parameter read refused");
   chk_level_clear: assert property (@(posedge mclk_in)
      $rose(rst_n) |-> !st_reg.lvl1 && !st_reg.lvl2 && !st_reg.l3ok && busy_out)
      else $error("security level survived reset");
   chk_flash_adjust: assert property (@(posedge mclk_in) disable iff (!rst_n)
      flash_out |-> st_reg.adjust)
      else $error("flash outside adjustment");
   chk_mode_toggle: assert property (@(posedge mclk_in) disable iff (!rst_n)
      mode_key_in && !sel_menu_stb_in && !sel_param_stb_in |=>
      st_reg.adjust != $past(st_reg.adjust))
      else $error("mode key did not toggle adjustment");
   chk_hide_index: assert property (@(posedge mclk_in) disable iff (!rst_n)
      sel_param_stb_in && attr_invisible_in && !st_reg.lvl2 |=> index_blank_out)
      else $error("invisible parameter shown in index");
endmodule : pac_store

/* tb/pac_host_model.sv */
`timescale 1ns/1ns
module pac_host_model
   import pac_pkg::*;
(
   // Clock
   input wire logic mclk_in,
   // Answers from the store
   input wire logic [PAC_DATA_W-1:0] rdata_in,
   input wire logic rd_err_in,
   input wire logic wr_err_in,
   // Register port requests
   output logic [PAC_ADDR_W-1:0] addr_out,
   output logic [PAC_DATA_W-1:0] wdata_out,
   output logic [1:0] wsrc_out,
   output logic wr_stb_out,
   output logic rd_stb_out,
   // Keypad keys
   output logic sel_menu_stb_out,
   output logic sel_param_stb_out,
   output logic [PAC_MENU_W-1:0] sel_menu_out,
   output logic [PAC_PARAM_W-1:0] sel_param_out,
   output logic mode_key_out
);
   // Idle levels at time zero
   initial begin
      {addr_out, wdata_out, wsrc_out, wr_stb_out, rd_stb_out} = '0;
      {sel_menu_stb_out, sel_param_stb_out, sel_menu_out, sel_param_out, mode_key_out} = '0;
   end
   //////////////////////////////////////////////////////////////////////////////
   // One request; lines scrambled on release so stale values cannot pass
   task automatic xfer(input logic w, input logic [PAC_ADDR_W-1:0] a,
                       input logic [PAC_DATA_W-1:0] d, input logic [1:0] s,
                       output logic [PAC_DATA_W-1:0] q, output logic e);
      @(posedge mclk_in);
      addr_out <= a;
      wdata_out <= d;
      wsrc_out <= s;
      wr_stb_out <= w;
      rd_stb_out <= !w;
      @(posedge mclk_in);
      wr_stb_out <= 1'b0;
      rd_stb_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      #1;
      q = rdata_in;
      e = w ? wr_err_in : rd_err_in;
   endtask : xfer
   // Keypad: 0 menu key, 1 parameter key, 2 mode key (press once in, again out)
   task automatic key(input int kind, input int m, input int p);
      @(posedge mclk_in);
      sel_menu_out <= PAC_MENU_W'(m);
      sel_param_out <= PAC_PARAM_W'(p);
      sel_menu_stb_out <= (kind == 0);
      sel_param_stb_out <= (kind == 1);
      mode_key_out <= (kind == 2);
      @(posedge mclk_in);
      {sel_menu_stb_out, sel_param_stb_out, mode_key_out} <= 3'h0;
   endtask : key
endmodule : pac_host_model

/* tb/tb_parameter_access_control.sv */
`timescale 1ns/1ns
module tb_parameter_access_control
   import pac_pkg::*;
;
   typedef struct {logic rd; logic [9:0] a; logic [11:0] d; logic [1:0] s;
      logic [5:0] at; logic e; logic [11:0] x;} pac_row_t;
   logic mclk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [9:0] addr, ctl_addr_in = '0;
   logic [11:0] wdata, rdata, ctl_data;
   logic [1:0] wsrc;
   logic wr_stb, rd_stb, rd_err, wr_err, blank, flash, busy;
   logic [5:0] attr = '0;
   logic drv_reset_in = 1'b0;
   logic drv_stopped_in = 1'b0;
   logic meas_we_in = 1'b0;
   logic ms, ps, mk;
   logic [4:0] sm, sp, imenu, iparam;
   int errors = 0;
   int total_checks = 0;
   // Bits of attr: read-only, invisible, bit, free, deferred, input-driven
   pac_row_t rows [15] = '{
      '{1'b0, 10'h025, 12'h064, 2'h0, 6'h04, 1'b0, 12'h000},
      '{1'b1, 10'h025, 12'h000, 2'h1, 6'h04, 1'b0, 12'h064},
      '{1'b0, 10'h027, 12'h064, 2'h0, 6'h00, 1'b1, 12'h000},
      '{1'b1, 10'h027, 12'h000, 2'h0, 6'h00, 1'b0, 12'h000},
      '{1'b0, 10'h064, 12'h064, 2'h1, 6'h20, 1'b1, 12'h000},
      '{1'b1, 10'h064, 12'h000, 2'h1, 6'h30, 1'b1, 12'h000},
      '{1'b0, 10'h020, PAC_CODE_LVL1, 2'h0, 6'h00, 1'b0, 12'h000},
      '{1'b0, 10'h027, 12'h7CF, 2'h1, 6'h00, 1'b0, 12'h000},
      '{1'b0, 10'h028, 12'h7D0, 2'h2, 6'h00, 1'b1, 12'h000},
      '{1'b0, 10'h043, 12'h002, 2'h0, 6'h08, 1'b1, 12'h000},
      '{1'b0, 10'h094, 12'h064, 2'h0, 6'h10, 1'b1, 12'h000},
      '{1'b0, 10'h0A0, PAC_CODE_LVL2, 2'h0, 6'h00, 1'b0, 12'h000},
      '{1'b0, 10'h094, 12'h831, 2'h2, 6'h10, 1'b0, 12'h000},
      '{1'b1, 10'h094, 12'h000, 2'h1, 6'h10, 1'b0, 12'h831},
      '{1'b0, 10'h0C9, 12'h064, 2'h0, 6'h01, 1'b1, 12'h000}};
   logic [11:0] fcode [3] = '{PAC_CODE_FACT_NREG, PAC_CODE_FACT_NREG, PAC_CODE_FACT_REG};
   // Clock at 100 MHz
   always #5 mclk_in = ~mclk_in;
   //////////////////////////////////////////////////////////////////////////////
   pac_store uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr),
      .wdata_in(wdata), .wsrc_in(wsrc), .wr_stb_in(wr_stb), .rd_stb_in(rd_stb),
      .rdata_out(rdata), .rd_err_out(rd_err), .wr_err_out(wr_err),
      .attr_read_only_class_in(attr[5]), .attr_invisible_in(attr[4]), .attr_bit_in(attr[3]),
      .attr_free_in(attr[2]), .attr_deferred_in(attr[1]), .attr_input_driven_in(attr[0]),
      .meas_we_in(meas_we_in), .drv_reset_in(drv_reset_in), .drv_stopped_in(drv_stopped_in),
      .ctl_addr_in(ctl_addr_in), .ctl_data_out(ctl_data), .sel_menu_stb_in(ms),
      .sel_param_stb_in(ps), .sel_menu_in(sm), .sel_param_in(sp), .mode_key_in(mk),
      .index_menu_out(imenu), .index_param_out(iparam), .index_blank_out(blank),
      .flash_out(flash), .busy_out(busy));
   pac_host_model host (.mclk_in(mclk_in), .rdata_in(rdata), .rd_err_in(rd_err),
      .wr_err_in(wr_err), .addr_out(addr), .wdata_out(wdata), .wsrc_out(wsrc),
      .wr_stb_out(wr_stb), .rd_stb_out(rd_stb), .sel_menu_stb_out(ms),
      .sel_param_stb_out(ps), .sel_menu_out(sm), .sel_param_out(sp), .mode_key_out(mk));
   //////////////////////////////////////////////////////////////////////////////
   // Comparisons
   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wr_chk(input logic [9:0] a, input logic [11:0] d, input logic [1:0] s,
                         input logic [5:0] at, input logic e);
      logic [11:0] q;
      logic g;
      @(posedge mclk_in);
      attr <= at;
      host.xfer(1'b1, a, d, s, q, g);
      chk_bit(g, e);
   endtask : wr_chk
   task automatic rd_chk(input logic [9:0] a, input logic [5:0] at, input logic e,
                         input logic [11:0] x);
      logic [11:0] q;
      logic g;
      @(posedge mclk_in);
      attr <= at;
      host.xfer(1'b0, a, 12'h000, 2'h1, q, g);
      chk_bit(g, e);
      chk_val(q, x);
   endtask : rd_chk
   // Wait out the load walk, bounded
   task automatic wait_idle();
      repeat (3) @(posedge mclk_in);
      for (int n = 0; n < 1200 && busy !== 1'b0; n++) @(posedge mclk_in);
      #1 chk_bit(busy, 1'b0);
   endtask : wait_idle
   task automatic power();
      @(posedge mclk_in);
      reset_n_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      reset_n_in <= 1'b1;
      wait_idle();
   endtask : power
   task automatic drv_rst();
      @(posedge mclk_in);
      drv_reset_in <= 1'b1;
      @(posedge mclk_in);
      drv_reset_in <= 1'b0;
   endtask : drv_rst
   task automatic ctl_chk(input logic [9:0] a, input logic [11:0] x);
      @(posedge mclk_in);
      ctl_addr_in <= a;
      repeat (2) @(posedge mclk_in);
      #1 chk_val(ctl_data, x);
   endtask : ctl_chk
   task automatic look(input logic f, input logic x);
      repeat (2) @(posedge mclk_in);
      #1 chk_bit(f ? flash : blank, x);
   endtask : look
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   //////////////////////////////////////////////////////////////////////////////
   // Watchdog at about 39 load walks, well beyond the eight the test runs
   initial begin
      repeat (40000) @(posedge mclk_in);
      errors++;
      test_done();
   end
   // Main sequence
   initial begin
      power();
      foreach (rows[i]) begin
         if (rows[i].rd) rd_chk(rows[i].a, rows[i].at, rows[i].e, rows[i].x);
         else wr_chk(rows[i].a, rows[i].d, rows[i].s, rows[i].at, rows[i].e);
      end
      // Drive-owned write lands on the lines left inverted by the last transfer
      @(posedge mclk_in);
      meas_we_in <= 1'b1;
      @(posedge mclk_in);
      meas_we_in <= 1'b0;
      rd_chk(10'h336, 6'h20, 1'b0, 12'hF9B);
      // Immediate use versus use after reset; writes refused while walking
      ctl_chk(10'h027, 12'h7CF);
      wr_chk(10'h16C, 12'h005, 2'h1, 6'h02, 1'b0);
      rd_chk(10'h16C, 6'h02, 1'b0, 12'h005);
      ctl_chk(10'h16C, 12'h000);
      drv_rst();
      wr_chk(10'h025, 12'h001, 2'h0, 6'h04, 1'b1);
      wait_idle();
      ctl_chk(10'h16C, 12'h005);
      // Keypad recall and flashing
      host.key(0, 1, 0);
      host.key(1, 1, 7);
      host.key(0, 2, 0);
      host.key(0, 1, 0);
      #1 chk_val({7'h00, iparam}, 12'h007);
      chk_val({7'h00, imenu}, 12'h001);
      host.key(2, 1, 7);
      look(1'b1, 1'b1);
      host.key(2, 1, 7);
      look(1'b1, 1'b0);
      attr <= 6'h20;
      host.key(1, 1, 4);
      host.key(2, 1, 4);
      look(1'b1, 1'b0);
      host.key(2, 1, 4);
      // Save, unsaved change, power cycle
      wr_chk(10'h020, PAC_CODE_SAVE, 2'h0, 6'h00, 1'b0);
      drv_rst();
      wait_idle();
      wr_chk(10'h025, 12'h033, 2'h0, 6'h04, 1'b0);
      power();
      rd_chk(10'h027, 6'h00, 1'b0, 12'h7CF);
      rd_chk(10'h025, 6'h04, 1'b0, 12'h064);
      wr_chk(10'h028, 12'h001, 2'h0, 6'h00, 1'b1);
      attr <= 6'h10;
      host.key(0, 4, 0);
      host.key(1, 4, 20);
      look(1'b0, 1'b1);
      // Factory reloads, first one refused while running
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk_in);
         drv_stopped_in <= (i != 0);
         wr_chk(10'h025, 12'h064, 2'h0, 6'h04, 1'b0);
         wr_chk(10'h040, fcode[i], 2'h0, 6'h00, 1'b0);
         drv_rst();
         wait_idle();
         rd_chk(10'h025, 6'h04, 1'b0, (i == 0) ? 12'h064 : 12'h000);
      end
      // Third-level code set, saved, and power cycled
      wr_chk(10'h020, PAC_CODE_LVL2, 2'h0, 6'h00, 1'b0);
      wr_chk(PAC_SEC_ADDR, 12'h07B, 2'h1, 6'h10, 1'b0);
      wr_chk(10'h020, PAC_CODE_SAVE, 2'h0, 6'h00, 1'b0);
      drv_rst();
      wait_idle();
      power();
      rd_chk(10'h025, 6'h04, 1'b1, 12'h000);
      wr_chk(10'h020, PAC_CODE_LVL1, 2'h0, 6'h00, 1'b0);
      wr_chk(10'h025, 12'h011, 2'h0, 6'h04, 1'b1);
      wr_chk(10'h020, 12'h07B, 2'h0, 6'h00, 1'b0);
      wr_chk(10'h020, PAC_CODE_LVL1, 2'h0, 6'h00, 1'b0);
      rd_chk(10'h025, 6'h04, 1'b0, 12'h000);
      test_done();
   end
endmodule : tb_parameter_access_control
